// File: verilog/jsbu_params.svh
// Purpose: constants of the jump/subroutine branch unit
// Assumes: 32-bit program addresses, byte-addressed stack
// Notes:   header holds definitions only
`ifndef JSBU_PARAMS_SVH
`define JSBU_PARAMS_SVH

`define JSBU_ADDR_W        32
`define JSBU_TRUE_BIT      1
`define JSBU_EXC_BIT       18
`define JSBU_SP_STATUS_OFF 32'h0000_0004
`define JSBU_SP_ADVANCE    32'h0000_0008
`define JSBU_CYC_JMPD      4'h3
`define JSBU_CYC_JSR       4'h3
`define JSBU_CYC_JSR_LONG  4'h4
`define JSBU_CYC_JSRD      4'h2
`define JSBU_CYC_JSRD_LONG 4'h3
`define JSBU_CYC_JT_TAKEN  4'h4
`define JSBU_CYC_ONE       4'h1
`define JSBU_GROUP_LONG    4'h3
`define JSBU_SET_STEP      32'h0000_0000
`define JSBU_ZERO_WORD     32'h0000_0000
`define JSBU_CYC_ZERO      4'h0

`endif

// File: verilog/jsbu_pkg.sv
// Purpose: types of the jump/subroutine branch unit
// Assumes: no params header; the encodings are fixed in this package
// Notes:   operation codes are this block's own, not opcode bits
package jsbu_pkg;

  typedef enum logic [2:0] {
    JSBU_OP_JMPD = 3'h0,
    JSBU_OP_JSR  = 3'h1,
    JSBU_OP_JSRD = 3'h2,
    JSBU_OP_JT   = 3'h3,
    JSBU_OP_JTD  = 3'h4
  } jsbu_op_t;

  // gray path: idle -> slot -> push_pc -> push_sr -> wait
  typedef enum logic [2:0] {
    JSBU_ST_IDLE = 3'b000,
    JSBU_ST_SLOT = 3'b001,
    JSBU_ST_PCW  = 3'b011,
    JSBU_ST_SRW  = 3'b010,
    JSBU_ST_WAIT = 3'b110
  } jsbu_state_t;

endpackage

// File: verilog/jsbu_cycles.sv
// Purpose: cycle cost of one control transfer
// Assumes: delay-slot time and group time given in cycles
// Notes:   pure combinational, floored at one cycle
`timescale 1ns/10ps
`include "jsbu_params.svh"
module jsbu_cycles
  import jsbu_pkg::*;
(
  input  wire jsbu_op_t   op_in,
  input  wire logic       taken_in,
  input  wire logic [3:0] group_max_in,
  input  wire logic [3:0] slot_time_in,
  output logic      [3:0] cycles_out
);

  wire       group_long = (group_max_in >= `JSBU_GROUP_LONG);
  wire [3:0] jsr_base   = group_long ? `JSBU_CYC_JSR_LONG : `JSBU_CYC_JSR;
  wire [3:0] jsrd_base  = group_long ? `JSBU_CYC_JSRD_LONG : `JSBU_CYC_JSRD;
  logic [3:0] base;
  logic       delayed;

  // base cost and whether the slot time is deducted
  always_comb begin
    base    = `JSBU_CYC_ONE;
    delayed = 1'b0;
    case (op_in)
      JSBU_OP_JMPD: begin
        base    = `JSBU_CYC_JMPD;
        delayed = 1'b1;
      end
      JSBU_OP_JSR:  base = jsr_base;
      JSBU_OP_JSRD: begin
        base    = jsrd_base;
        delayed = 1'b1;
      end
      JSBU_OP_JT:   base = taken_in ? `JSBU_CYC_JT_TAKEN : `JSBU_CYC_ONE;
      JSBU_OP_JTD: begin
        base    = taken_in ? `JSBU_CYC_JT_TAKEN : `JSBU_CYC_ONE;
        delayed = taken_in;
      end
      default:      base = `JSBU_CYC_ONE;
    endcase
  end

  // deduct slot time, never below one cycle
  wire [3:0] reduced = (base > slot_time_in) ? base - slot_time_in : `JSBU_CYC_ZERO;
  assign cycles_out = (delayed && (reduced < `JSBU_CYC_ONE)) ? `JSBU_CYC_ONE :
                      (delayed ? reduced : base);
endmodule

// File: verilog/jsbu_unit.sv
// Purpose: program-flow control for jumps, calls and conditional jumps
// Assumes: fetch side supplies decoded operation, words and set addresses
// Notes:   stack writes go out as two single-cycle memory write strobes
`timescale 1ns/10ps
`include "jsbu_params.svh"
// Operation
// - delayed jump runs delay-slot set, then goes to absolute or register target
// - delayed jump costs three cycles less slot time, at least one
// - call writes return PC at stack pointer, status at +4, pointer += 8
// - plain call saves next set address and loads it into return shadow
// - exception-mode bit 18 picks which stack pointer is used and advanced
// - plain call costs three cycles, four when grouped work takes three or more
// - delayed call runs slot first, pushes post-slot set address and status
// - delayed call loads post-slot address into shadow and marks it valid
// - delayed call costs two or three less slot time, at least one
// - plain jump-on-true goes to target when true bit set, else sequential
// - plain jump-on-true costs one cycle not taken, four taken
// - delayed jump-on-true runs slot then target if true, else sequential
// - delayed jump-on-true: one untaken, four less slot time taken, floor one
// - three-bit field selects registers 0-7, high prefix selects 8-15
module jsbu_unit
  import jsbu_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        issue_in,
  input  wire jsbu_op_t    op_in,
  input  wire logic        long_form_in,
  input  wire logic [15:0] word1_in,
  input  wire logic [15:0] word2_in,
  input  wire logic [15:0] word3_in,
  input  wire logic [2:0]  address_register_field_in,
  input  wire logic        high_prefix_in,
  input  wire logic [31:0] address_register_file_in [16],
  input  wire logic [31:0] status_word_in,
  input  wire logic [31:0] stack_pointer_in,
  input  wire logic [31:0] exc_stack_pointer_in,
  input  wire logic [31:0] next_set_pc_in,
  input  wire logic [31:0] post_slot_pc_in,
  input  wire logic [3:0]  group_max_in,
  input  wire logic [3:0]  slot_time_in,
  input  wire logic        slot_done_in,
  output logic             busy_out,
  output logic             pc_load_out,
  output logic [31:0]      pc_target_out,
  output logic             suppress_out,
  output logic             mem_we_out,
  output logic [31:0]      mem_addr_out,
  output logic [31:0]      mem_data_out,
  output logic             sp_we_out,
  output logic             sp_sel_exc_out,
  output logic [31:0]      sp_value_out,
  output logic             ras_we_out,
  output logic [31:0]      ras_out,
  output logic             ras_valid_out,
  output logic [3:0]       cycles_out
);

  jsbu_state_t state;
  jsbu_state_t next_state;
  jsbu_op_t    op;
  logic [31:0] target;
  logic [31:0] ret_pc;
  logic [31:0] status_word;
  logic [31:0] sp_base;
  logic        use_exc;
  logic [3:0]  wait_cnt;
  logic        jump_now;

  // target assembly: long form uses words one, two and three, short form a register
  wire [3:0]  reg_index   = {high_prefix_in, address_register_field_in};
  wire [31:0] imm_target  = {word1_in[7:5], word1_in[4:3], word2_in[12:0], word3_in[13:0]};
  wire [31:0] reg_target  = address_register_file_in[reg_index];
  wire [31:0] sel_target  = long_form_in ? imm_target : reg_target;
  wire        true_flag   = status_word_in[`JSBU_TRUE_BIT];
  wire        exc_mode    = status_word_in[`JSBU_EXC_BIT];
  wire        is_call     = (op_in == JSBU_OP_JSR) || (op_in == JSBU_OP_JSRD);
  wire        is_cond     = (op_in == JSBU_OP_JT) || (op_in == JSBU_OP_JTD);
  wire        is_delayed  = (op_in == JSBU_OP_JMPD) || (op_in == JSBU_OP_JSRD) ||
                            (op_in == JSBU_OP_JTD);
  wire        taken       = is_cond ? true_flag : 1'b1;
  wire        accept      = issue_in && (state == JSBU_ST_IDLE);
  wire [31:0] chosen_sp   = exc_mode ? exc_stack_pointer_in : stack_pointer_in;
  wire [31:0] call_ret    = (op_in == JSBU_OP_JSRD) ? post_slot_pc_in : next_set_pc_in;
  wire        is_call_q   = (op == JSBU_OP_JSR) || (op == JSBU_OP_JSRD);
  wire [3:0]  cost;

  jsbu_cycles u_cycles (
    .op_in        (op_in),
    .taken_in     (taken),
    .group_max_in (group_max_in),
    .slot_time_in (slot_time_in),
    .cycles_out   (cost)
  );

  // sequencing of slot wait, stack pushes and cycle padding
  always_comb begin
    next_state = state;
    jump_now   = 1'b0;
    case (state)
      JSBU_ST_IDLE: begin
        if (accept && taken) begin
          if (is_delayed)
            next_state = JSBU_ST_SLOT;
          else if (is_call)
            next_state = JSBU_ST_PCW;
          else
            next_state = JSBU_ST_WAIT;
        end
      end
      JSBU_ST_SLOT: begin
        if (slot_done_in)
          next_state = is_call_q ? JSBU_ST_PCW : JSBU_ST_WAIT;
      end
      JSBU_ST_PCW:  next_state = JSBU_ST_SRW;
      JSBU_ST_SRW:  next_state = JSBU_ST_WAIT;
      JSBU_ST_WAIT: begin
        if (wait_cnt <= `JSBU_CYC_ONE) begin
          next_state = JSBU_ST_IDLE;
          jump_now   = 1'b1;
        end
      end
      default:      next_state = JSBU_ST_IDLE;
    endcase
  end

  // push phases and the padding count decoded from the state register
  wire        pushing_pc    = (state == JSBU_ST_PCW);
  wire        pushing_sr    = (state == JSBU_ST_SRW);
  wire        in_slot       = (state == JSBU_ST_SLOT);
  wire        counting      = (state != JSBU_ST_IDLE) && !in_slot;
  // slot time is already deducted from the cost, so the slot wait is not counted;
  // the count parks at one, which is the cycle that raises the load strobe
  wire        wait_step     = counting && (wait_cnt > `JSBU_CYC_ONE);
  wire [3:0]  next_wait     = wait_cnt - `JSBU_CYC_ONE;
  wire        next_busy     = (next_state != JSBU_ST_IDLE);
  // the slot set must still commit, so suppression starts after it
  wire        next_suppress = ((next_state != JSBU_ST_IDLE) && (next_state != JSBU_ST_SLOT)) ||
                              jump_now;
  // push addresses come from the pointer latched at accept
  wire [31:0] status_addr   = sp_base + `JSBU_SP_STATUS_OFF;
  wire [31:0] advanced_sp   = sp_base + `JSBU_SP_ADVANCE;

  // state register; only an idle unit takes an issue
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      state <= JSBU_ST_IDLE;
    else
      state <= next_state;
  end

  // operands frozen at accept, so later fetch traffic cannot disturb them
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op     <= JSBU_OP_JMPD;
      target <= `JSBU_ZERO_WORD;
    end else if (accept) begin
      op     <= op_in;
      target <= sel_target;
    end
  end

  // return value and status for the two pushes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ret_pc      <= `JSBU_ZERO_WORD;
      status_word <= `JSBU_ZERO_WORD;
    end else if (accept) begin
      ret_pc      <= call_ret;
      status_word <= status_word_in;
    end
  end

  // stack choice latched at accept; a later mode change cannot split the pushes
  // across the two pointers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_base <= `JSBU_ZERO_WORD;
      use_exc <= 1'b0;
    end else if (accept) begin
      sp_base <= chosen_sp;
      use_exc <= exc_mode;
    end
  end

  // cycle budget: push and padding cycles count against the instruction cost
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      wait_cnt <= `JSBU_CYC_ZERO;
    else if (accept)
      wait_cnt <= cost;
    else if (wait_step)
      wait_cnt <= next_wait;
  end

  // busy covers every cycle in which an issue would be refused
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      busy_out <= 1'b0;
    else
      busy_out <= next_busy;
  end

  // one-cycle load strobe; the target stays put until the next taken transfer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_load_out   <= 1'b0;
      pc_target_out <= `JSBU_ZERO_WORD;
    end else begin
      pc_load_out <= jump_now;
      if (jump_now)
        pc_target_out <= target;
    end
  end

  // later sets in flight are dropped while a taken transfer completes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      suppress_out <= 1'b0;
    else
      suppress_out <= next_suppress;
  end

  // cost of the last accepted operation, untaken ones included
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      cycles_out <= `JSBU_CYC_ZERO;
    else if (accept)
      cycles_out <= cost;
  end

  // memory strobe for both pushes, one cycle each
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      mem_we_out <= 1'b0;
    else
      mem_we_out <= pushing_pc || pushing_sr;
  end

  // return pc at the pointer, status one word above it;
  // address and data hold after the strobe drops
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_addr_out <= `JSBU_ZERO_WORD;
      mem_data_out <= `JSBU_ZERO_WORD;
    end else if (pushing_pc) begin
      mem_addr_out <= sp_base;
      mem_data_out <= ret_pc;
    end else if (pushing_sr) begin
      mem_addr_out <= status_addr;
      mem_data_out <= status_word;
    end
  end

  // pointer update rides with the status write so both land together
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      sp_we_out <= 1'b0;
    else
      sp_we_out <= pushing_sr;
  end

  // which pointer moves, and its new value
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_sel_exc_out <= 1'b0;
      sp_value_out   <= `JSBU_ZERO_WORD;
    end else if (pushing_sr) begin
      sp_sel_exc_out <= use_exc;
      sp_value_out   <= advanced_sp;
    end
  end

  // shadow write strobe, alongside the return-pc push
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ras_we_out <= 1'b0;
    else
      ras_we_out <= pushing_pc;
  end

  // shadow value holds until the next call overwrites it
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ras_out <= `JSBU_ZERO_WORD;
    else if (pushing_pc)
      ras_out <= ret_pc;
  end

  // valid flag is sticky: only reset clears it, since no return
  // instruction lives in this block
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ras_valid_out <= 1'b0;
    else if (pushing_pc)
      ras_valid_out <= 1'b1;
  end

endmodule

// File: testbench/jsbu_unit_monitor.sv
// Purpose: port checker for the branch unit
// Assumes: one clock, async active-low reset
// Notes:   bound to jsbu_unit below
`timescale 1ns/10ps
module jsbu_unit_monitor
  import jsbu_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        issue_in,
  input wire jsbu_op_t    op_in,
  input wire logic [31:0] status_word_in,
  input wire logic [3:0]  group_max_in,
  input wire logic        busy_out,
  input wire logic        pc_load_out,
  input wire logic        mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_data_out,
  input wire logic        sp_we_out,
  input wire logic        sp_sel_exc_out,
  input wire logic [31:0] sp_value_out,
  input wire logic        ras_we_out,
  input wire logic [31:0] ras_out,
  input wire logic        ras_valid_out,
  input wire logic [3:0]  cycles_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // accepted requests; a busy unit drops them
  wire logic acc = issue_in && !busy_out;
  wire logic jt_acc = acc && (op_in == JSBU_OP_JT);
  sequence pc_push_s; mem_we_out && !sp_we_out; endsequence
  sequence sr_push_s; mem_we_out && sp_we_out; endsequence
  sequence wait4_s; !pc_load_out [*4] ##1 pc_load_out; endsequence
  push_pair_a: assert property (pc_push_s |=> sr_push_s ##0 mem_addr_out == $past(mem_addr_out) + 32'h4)
    else $error("status push misplaced");
  sp_step_a: assert property (sp_we_out |-> sp_value_out == mem_addr_out + 32'h4)
    else $error("stack pointer advance wrong");
  stack_sel_a: assert property (sp_we_out |-> sp_sel_exc_out == mem_data_out[18])
    else $error("wrong stack pointer chosen");
  ras_load_a: assert property (ras_we_out |-> pc_push_s ##0 ras_out == mem_data_out && ras_valid_out)
    else $error("shadow differs from pushed return");
  ras_sticky_a: assert property (ras_valid_out |=> ras_valid_out)
    else $error("shadow valid dropped");
  jt_skip_a: assert property (jt_acc && !status_word_in[1] |=> cycles_out == 4'h1 && !pc_load_out)
    else $error("untaken jump misbehaved");
  jt_taken_a: assert property (jt_acc && status_word_in[1] |=> wait4_s)
    else $error("taken jump not at fourth cycle");
  jsr_cost_a: assert property (acc && op_in == JSBU_OP_JSR |=>
    cycles_out == (($past(group_max_in) >= 4'h3) ? 4'h4 : 4'h3))
    else $error("call cost wrong");
endmodule
bind jsbu_unit jsbu_unit_monitor mon (.core_clk_in, .rst_n_in, .issue_in, .op_in, .status_word_in, .group_max_in,
  .busy_out, .pc_load_out, .mem_we_out, .mem_addr_out, .mem_data_out, .sp_we_out, .sp_sel_exc_out, .sp_value_out,
  .ras_we_out, .ras_out, .ras_valid_out, .cycles_out);

// File: testbench/jsbu_fetch_model.sv
// Purpose: fetch side that runs the delay-slot set
// Assumes: slot latency in cycles from the bench
// Notes:   latency 1 is prompt, larger values stall
`timescale 1ns/10ps
module jsbu_fetch_model (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       busy_in,
  input  wire logic       delayed_in,
  input  wire logic [3:0] lat_in,
  output logic            slot_done_out
);
  logic       busy_q;
  logic [3:0] cnt;
  // slot set starts when the unit turns busy on a delayed transfer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q        <= 1'h0;
      cnt           <= 4'h0;
      slot_done_out <= 1'h0;
    end else begin
      busy_q        <= busy_in;
      cnt           <= (busy_in && !busy_q && delayed_in) ? lat_in : (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
      slot_done_out <= (cnt == 4'h1);
    end
  end
endmodule

// File: testbench/jsbu_unit_tb.sv
// Purpose: self-checking bench for the branch unit
// Assumes: inputs change on the falling edge
// Notes:   row fields {pad,op} {long,true,exc,taken} group slot cycles
`timescale 1ns/10ps
module jsbu_unit_tb
  import jsbu_pkg::*;
;
  typedef struct packed {logic pad; jsbu_op_t op; logic lg, t, ex, tk; logic [3:0] grp, slot, cyc;} jsbu_row_t;
  jsbu_row_t   rows [11];
  int          err_total, cmp_count, loads;
  logic        core_clk_in, rst_n_in, issue_in, long_form_in, high_prefix_in, dly, slot_done_in, busy_out;
  logic        pc_load_out, suppress_out, mem_we_out, sp_we_out, sp_sel_exc_out, ras_we_out, ras_valid_out;
  jsbu_op_t    op_in;
  logic [15:0] word1_in, word2_in, word3_in;
  logic [2:0]  address_register_field_in;
  logic [3:0]  group_max_in, slot_time_in, lat, cycles_out;
  logic [31:0] address_register_file_in [16];
  logic [31:0] status_word_in, stack_pointer_in, exc_stack_pointer_in, next_set_pc_in, post_slot_pc_in, b;
  logic [31:0] pc_target_out, mem_addr_out, mem_data_out, sp_value_out, ras_out, wa [$], wd [$];
  jsbu_unit uut (.core_clk_in, .rst_n_in, .issue_in, .op_in, .long_form_in, .word1_in, .word2_in, .word3_in,
    .address_register_field_in, .high_prefix_in, .address_register_file_in, .status_word_in, .stack_pointer_in,
    .exc_stack_pointer_in, .next_set_pc_in, .post_slot_pc_in, .group_max_in, .slot_time_in, .slot_done_in,
    .busy_out, .pc_load_out, .pc_target_out, .suppress_out, .mem_we_out, .mem_addr_out, .mem_data_out, .sp_we_out,
    .sp_sel_exc_out, .sp_value_out, .ras_we_out, .ras_out, .ras_valid_out, .cycles_out);
  jsbu_fetch_model fetch (.core_clk_in, .rst_n_in, .busy_in(busy_out), .delayed_in(dly), .lat_in(lat),
    .slot_done_out(slot_done_in));
  always #5 core_clk_in = ~core_clk_in;
  // stack writes in order of arrival
  always @(posedge core_clk_in) if (mem_we_out === 1'h1) begin
    wa.push_back(mem_addr_out);
    wd.push_back(mem_data_out);
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // present row i; pointers move per row so stale values show
  task automatic drive(input int i);
    b = {24'h0, i[3:0], 4'h0};
    {op_in, long_form_in} = {rows[i].op, rows[i].lg};
    {word1_in, word2_in, word3_in} = {16'h00F0, 16'h1ABC, 16'h2468};
    {high_prefix_in, address_register_field_in} = i[3:0];
    status_word_in = {13'h0, rows[i].ex, 16'h0, rows[i].t, 1'h0};
    {stack_pointer_in, exc_stack_pointer_in} = {32'h0000_0100 + b, 32'h0000_0800 + b};
    {next_set_pc_in, post_slot_pc_in} = {32'h0000_0010 + b, 32'h0000_0020 + b};
    {group_max_in, slot_time_in, lat} = {rows[i].grp, rows[i].slot, i[0] ? 4'h4 : 4'h1};
    dly = rows[i].op inside {JSBU_OP_JMPD, JSBU_OP_JSRD, JSBU_OP_JTD};
    issue_in = 1'h1;
  endtask
  task automatic run(input int i);
    logic ld, call, sup;
    logic [31:0] sp, ret, tg;
    int at;
    @(negedge core_clk_in);
    drive(i);
    wa.delete();
    wd.delete();
    call = rows[i].op inside {JSBU_OP_JSR, JSBU_OP_JSRD};
    sp = rows[i].ex ? exc_stack_pointer_in : stack_pointer_in;
    ret = (rows[i].op == JSBU_OP_JSRD) ? post_slot_pc_in : next_set_pc_in;
    tg = long_form_in ? {word1_in[7:3], word2_in[12:0], word3_in[13:0]} : address_register_file_in[i];
    ld = 1'h0;
    sup = 1'h0;
    at = 0;
    @(negedge core_clk_in);
    issue_in = 1'h0;
    for (int n = 0; n < 30; n++) begin
      if (pc_load_out === 1'h1) begin
        ld = 1'h1;
        at = n;
      end
      if (suppress_out === 1'h1) sup = 1'h1;
      if (busy_out === 1'h0 && n > 0) break;
      @(negedge core_clk_in);
    end
    chk("busy", 32'h0, {31'h0, busy_out});
    chk("cycles", {28'h0, rows[i].cyc}, {28'h0, cycles_out});
    chk("load", {31'h0, rows[i].tk}, {31'h0, ld});
    if (rows[i].tk) chk("target", tg, pc_target_out);
    chk("suppress", {63'h0, rows[i].tk}, {63'h0, sup});
    if (rows[i].tk && rows[i].op inside {JSBU_OP_JSR, JSBU_OP_JT})
      chk("load cycle", {60'h0, rows[i].cyc}, 64'(at));
    chk("pushes", call ? 32'h2 : 32'h0, 32'(wa.size()));
    if (call) begin
      chk("pc push", {sp, ret}, {wa[0], wd[0]});
      chk("sr push", {sp + 32'h4, status_word_in}, {wa[1], wd[1]});
      chk("sp", sp + 32'h8, sp_value_out);
      chk("shadow", {ret, 32'h1}, {ras_out, 31'h0, ras_valid_out});
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence: table, then refusal and mid-run reset
  initial begin
    {core_clk_in, rst_n_in, err_total, cmp_count} = '0;
    rows = '{20'h01012, 20'h09051, 20'h11203, 20'h1B304, 20'h21011, 20'h2B412, 20'h35004, 20'h38001,
             20'h45022, 20'h48011, 20'h45061};
    foreach (address_register_file_in[k]) address_register_file_in[k] = 32'h1000_0000 + 32'(k * 64);
    drive(0);
    issue_in = 1'h0;
    repeat (10) @(negedge core_clk_in);
    rst_n_in = 1'h1;
    @(negedge core_clk_in);
    chk("idle", 32'h0, {29'h0, busy_out, pc_load_out, ras_valid_out});
    for (int i = 0; i < 11; i++) run(i);
    @(negedge core_clk_in);
    drive(2);
    @(negedge core_clk_in);
    drive(6);
    @(negedge core_clk_in);
    issue_in = 1'h0;
    loads = 0;
    repeat (12) begin
      if (pc_load_out === 1'h1) loads++;
      @(negedge core_clk_in);
    end
    chk("refused", 32'h1, 32'(loads));
    chk("refused cost", 32'h3, {28'h0, cycles_out});
    drive(3);
    @(negedge core_clk_in);
    {issue_in, rst_n_in} = 2'h0;
    @(negedge core_clk_in);
    chk("reset", 32'h0, {30'h0, busy_out, ras_valid_out});
    rst_n_in = 1'h1;
    run(5);
    final_report();
  end
  // watchdog well past the expected run of roughly a hundred cycles
  initial begin
    #20000;
    err_total++;
    final_report();
  end
endmodule
